// >>> shared/sync_status_pkg.sv
package sync_status_pkg;
    // Serial word framing: address in the low bits
    localparam int WORD_W = 32;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_SYNC_CTRL = 5'h0b;
    localparam logic [4:0] ADDR_LOCK_CTRL = 5'h0c;
    localparam logic [4:0] ADDR_HOLD_CTRL = 5'h0d;
    localparam logic [4:0] ADDR_DELAY_LAST = 5'h05;
    localparam int NUM_OUT = 6;
    localparam int NUM_SRC = 19;
    // Sync control word fields
    localparam int SYNC_EN_BIT = 26;
    localparam int EXCLUDE_LSB = 20;
    localparam int SYNC_SRC_LSB = 18;
    localparam int QUALIFY_BIT = 17;
    localparam int POL_BIT = 16;
    localparam int AUTO_BIT = 15;
    localparam int SYNC_TYPE_LSB = 12;
    localparam int XTAL_BIT = 5;
    // Lock and holdover pin words
    localparam int PIN_SRC_LSB = 27;
    localparam int PIN_TYPE_LSB = 24;
    localparam int HOLD_L2_BIT = 23;
    localparam int HOLD_L1_BIT = 22;
    localparam int TRACK_BIT = 8;
    localparam int HMODE_LSB = 6;
    // Encodings
    localparam logic [2:0] IO_IN = 3'h0;
    localparam logic [2:0] IO_IN_PULLUP = 3'h1;
    localparam logic [2:0] IO_IN_PULLDOWN = 3'h2;
    localparam logic [2:0] IO_PUSH = 3'h3;
    localparam logic [2:0] IO_PUSH_INV = 3'h4;
    localparam logic [2:0] IO_OPEN_SOURCE = 3'h5;
    localparam logic [2:0] IO_OPEN_DRAIN = 3'h6;
    localparam logic [1:0] SYNC_SRC_LOW = 2'h0;
    localparam logic [1:0] SYNC_SRC_READBACK = 2'h3;
    localparam logic [4:0] SRC_LOW = 5'h00;
    localparam logic [4:0] SRC_RESERVED = 5'h06;
    localparam logic [4:0] SRC_READBACK = 5'h07;
    localparam logic [1:0] HMODE_ON = 2'h2;
    // Values after reset
    localparam logic [31:0] SYNC_CTRL_RESET = 32'h0400_000b;
    localparam logic [31:0] LOCK_CTRL_RESET = 32'h0300_004c;
    localparam logic [31:0] HOLD_CTRL_RESET = 32'h0300_000d;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_type;

    typedef enum logic [2:0] {
        SYNC_IDLE = 3'b001,
        SYNC_ACTIVE = 3'b010,
        SYNC_RELEASE = 3'b100
    } sync_state_type;
endpackage : sync_status_pkg

// >>> core/sync_status_pin_control.sv
// Function
// - Sync enable bit gates all synchronization
// - Enable rising edge produces a sync event when unqualified
// - Per-output exclusion bits keep outputs running
// - Non-excluded outputs held low during sync
// - New delay applies only through sync
// - Exclusion never disturbs already aligned outputs
// - Sync pin source: low or readback
// - Output type 3 true, 4 inverted
// - Qualified sync timed by feedback-selected clock
// - Polarity bit sets input level, toggle syncs
// - Auto sync on latch fall after delay word, when unqualified
// - Sync pin io type encoding
// - Output pin forces internal sync input low
// - Bit five enables crystal amplifier
// - Lock pin source select, nineteen codes
// - Lock pin io type encoding and polarity
// - Hold unqualified sync until selected loops lock
// - Bit eight enables dac tracking
// - Holdover mode one off, two on
// - Holdover pin uses lock pin encoding
// - Feedback selector picks qualifying clock
`timescale 1ns/10ps
module sync_status_pin_control
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Three-wire serial programming port
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic serial_latch_enable_pin_i,
    input wire logic readback_data_i,
    // Device status sources and clocks
    input wire logic [sync_status_pkg::NUM_SRC-1:0] status_src_i,
    input wire logic digital_lock_detect_loop1_i,
    input wire logic digital_lock_detect_loop2_i,
    input wire logic [6:0] feedback_clk_i,
    input wire logic [2:0] feedback_select_i,
    // Sync pin
    input wire logic sync_pin_i,
    output logic sync_pin_o,
    output logic sync_pin_oe_o,
    output logic sync_pin_pullup_o,
    output logic sync_pin_pulldown_o,
    // Status pins
    output logic lock_status_pin_o,
    output logic lock_status_pin_oe_o,
    output logic holdover_pin_o,
    output logic holdover_pin_oe_o,
    // Datapath controls
    output logic [sync_status_pkg::NUM_OUT-1:0] output_sync_hold_o,
    output logic [sync_status_pkg::NUM_OUT-1:0] delay_load_o,
    output logic crystal_amp_enable_o,
    output logic dac_track_enable_o,
    output logic holdover_enable_o
);
    import sync_status_pkg::*;

    logic [WORD_W-1:0] shift;
    logic serial_clk_prev;
    logic latch_prev;
    logic [WORD_W-1:0] sync_control_word;
    logic [WORD_W-1:0] lock_pin_control_word;
    logic [WORD_W-1:0] holdover_pin_control_word;
    logic auto_pending;
    logic sync_en_prev;
    logic qual_clk_prev;
    sync_state_type state;
    sync_state_type next_state;

    // Serial port edges
    wire serial_rise = serial_clk_i & ~serial_clk_prev;
    wire latch_rise = serial_latch_enable_pin_i & ~latch_prev;
    wire latch_fall = ~serial_latch_enable_pin_i & latch_prev;
    wire [ADDR_W-1:0] word_addr = shift[ADDR_W-1:0];
    wire wr_sync = latch_rise && (word_addr == ADDR_SYNC_CTRL);
    wire wr_lock = latch_rise && (word_addr == ADDR_LOCK_CTRL);
    wire wr_hold = latch_rise && (word_addr == ADDR_HOLD_CTRL);
    wire wr_delay = latch_rise && (word_addr <= ADDR_DELAY_LAST);

    // Sync control fields
    wire sync_enable = sync_control_word[SYNC_EN_BIT];
    wire [NUM_OUT-1:0] output_sync_exclude =
        sync_control_word[EXCLUDE_LSB +: NUM_OUT];
    wire [1:0] sync_src = sync_control_word[SYNC_SRC_LSB +: 2];
    wire sync_qualify = sync_control_word[QUALIFY_BIT];
    wire sync_polarity_invert = sync_control_word[POL_BIT];
    wire sync_auto = sync_control_word[AUTO_BIT];
    wire [2:0] sync_io_type = sync_control_word[SYNC_TYPE_LSB +: 3];

    // Lock pin and holdover fields
    wire [4:0] lock_pin_source_select = lock_pin_control_word[PIN_SRC_LSB +: 5];
    wire [2:0] lock_pin_io_type = lock_pin_control_word[PIN_TYPE_LSB +: 3];
    wire hold_sync_until_loop2_lock = lock_pin_control_word[HOLD_L2_BIT];
    wire hold_sync_until_loop1_lock = lock_pin_control_word[HOLD_L1_BIT];
    wire [1:0] holdover_mode = lock_pin_control_word[HMODE_LSB +: 2];
    wire [4:0] hold_src_sel = holdover_pin_control_word[PIN_SRC_LSB +: 5];
    wire [2:0] hold_io_type = holdover_pin_control_word[PIN_TYPE_LSB +: 3];

    // Pin drive from io type and selected level
    function automatic pin_drive_type drive_pin(input logic [2:0] io_type,
                                                input logic level);
        pin_drive_type d;
        d.out = 1'b0;
        d.oe = 1'b0;
        case (io_type)
            IO_PUSH:
            begin
                d.out = level;
                d.oe = 1'b1;
            end
            IO_PUSH_INV:
            begin
                d.out = ~level;
                d.oe = 1'b1;
            end
            IO_OPEN_SOURCE:
            begin
                d.out = 1'b1;
                d.oe = level;
            end
            IO_OPEN_DRAIN:
            begin
                d.out = 1'b0;
                d.oe = ~level;
            end
            default:
            begin
                d.out = 1'b0;
                d.oe = 1'b0;
            end
        endcase
        return d;
    endfunction : drive_pin

    // Status source vector with fixed low, reserved and readback entries
    logic [NUM_SRC-1:0] src_vec;
    always_comb
    begin
        src_vec = status_src_i;
        src_vec[SRC_LOW] = 1'b0;
        src_vec[SRC_RESERVED] = 1'b0;
        src_vec[SRC_READBACK] = readback_data_i;
    end

    wire lock_level = (lock_pin_source_select < 5'(NUM_SRC)) ?
        src_vec[lock_pin_source_select] : 1'b0;
    wire hold_level = (hold_src_sel < 5'(NUM_SRC)) ?
        src_vec[hold_src_sel] : 1'b0;
    wire pin_drive_type lock_drive = drive_pin(lock_pin_io_type, lock_level);
    wire pin_drive_type hold_drive = drive_pin(hold_io_type, hold_level);

    // Sync pin as output or input
    wire sync_is_output = (sync_io_type >= IO_PUSH);
    wire sync_src_level = (sync_src == SYNC_SRC_READBACK) ?
        readback_data_i : 1'b0;
    wire pin_drive_type sync_drive = drive_pin(sync_io_type, sync_src_level);
    wire sync_in_raw = sync_is_output ? 1'b0 : sync_pin_i;
    wire sync_level = sync_in_raw ^ sync_polarity_invert;

    // Sync causes
    wire enable_rise = sync_enable & ~sync_en_prev;
    wire auto_event = auto_pending & latch_fall;
    wire lock_hold = ~sync_qualify &
        ((hold_sync_until_loop1_lock & ~digital_lock_detect_loop1_i) |
         (hold_sync_until_loop2_lock & ~digital_lock_detect_loop2_i));
    wire sync_request = sync_enable &
        (sync_level | enable_rise | auto_event | lock_hold);

    // Qualifying clock from feedback selector
    wire qual_clk = (feedback_select_i <= 3'h6) ?
        feedback_clk_i[feedback_select_i] : 1'b0;
    wire qual_edge = qual_clk & ~qual_clk_prev;
    wire sync_step = ~sync_qualify | qual_edge;

    // Sync sequencing: assert, then release and load delays
    always_comb
    begin
        next_state = state;
        case (state)
            SYNC_IDLE:
            begin
                if (sync_request && sync_step)
                begin
                    next_state = SYNC_ACTIVE;
                end
            end
            SYNC_ACTIVE:
            begin
                if (!sync_request && sync_step)
                begin
                    next_state = SYNC_RELEASE;
                end
            end
            SYNC_RELEASE:
            begin
                next_state = SYNC_IDLE;
            end
            default:
            begin
                next_state = SYNC_IDLE;
            end
        endcase
    end

    // Serial shift and edge history
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shift <= '0;
            serial_clk_prev <= 1'b0;
            latch_prev <= 1'b0;
            qual_clk_prev <= 1'b0;
        end
        else
        begin
            serial_clk_prev <= serial_clk_i;
            latch_prev <= serial_latch_enable_pin_i;
            qual_clk_prev <= qual_clk;
            if (serial_rise && !serial_latch_enable_pin_i)
            begin
                shift <= {shift[WORD_W-2:0], serial_data_i};
            end
        end
    end

    // Control words
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_control_word <= SYNC_CTRL_RESET;
            lock_pin_control_word <= LOCK_CTRL_RESET;
            holdover_pin_control_word <= HOLD_CTRL_RESET;
        end
        else
        begin
            if (wr_sync)
            begin
                sync_control_word <= shift;
            end
            if (wr_lock)
            begin
                lock_pin_control_word <= shift;
            end
            if (wr_hold)
            begin
                holdover_pin_control_word <= shift;
            end
        end
    end

    // Auto sync pending from latch rise to latch fall
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            auto_pending <= 1'b0;
            sync_en_prev <= SYNC_CTRL_RESET[SYNC_EN_BIT];
            state <= SYNC_IDLE;
        end
        else
        begin
            sync_en_prev <= sync_enable;
            state <= next_state;
            if (wr_delay && sync_auto)
            begin
                auto_pending <= 1'b1;
            end
            else if (latch_fall)
            begin
                auto_pending <= 1'b0;
            end
        end
    end

    // Per-output hold low and delay load
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++)
        begin : g_out
            wire include_out = ~output_sync_exclude[g];
            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    output_sync_hold_o[g] <= 1'b0;
                    delay_load_o[g] <= 1'b0;
                end
                else
                begin
                    // Excluded outputs keep their current alignment
                    output_sync_hold_o[g] <= include_out &&
                        (next_state == SYNC_ACTIVE);
                    delay_load_o[g] <= include_out &&
                        (next_state == SYNC_RELEASE);
                end
            end
        end
    endgenerate

    // Registered pins and static controls
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_pin_o <= 1'b0;
            sync_pin_oe_o <= 1'b0;
            sync_pin_pullup_o <= 1'b0;
            sync_pin_pulldown_o <= 1'b0;
            lock_status_pin_o <= 1'b0;
            lock_status_pin_oe_o <= 1'b0;
            holdover_pin_o <= 1'b0;
            holdover_pin_oe_o <= 1'b0;
            crystal_amp_enable_o <= 1'b0;
            dac_track_enable_o <= 1'b0;
            holdover_enable_o <= 1'b0;
        end
        else
        begin
            sync_pin_o <= sync_drive.out;
            sync_pin_oe_o <= sync_drive.oe;
            sync_pin_pullup_o <= (sync_io_type == IO_IN_PULLUP);
            sync_pin_pulldown_o <= (sync_io_type == IO_IN_PULLDOWN);
            lock_status_pin_o <= lock_drive.out;
            lock_status_pin_oe_o <= lock_drive.oe;
            holdover_pin_o <= hold_drive.out;
            holdover_pin_oe_o <= hold_drive.oe;
            crystal_amp_enable_o <= sync_control_word[XTAL_BIT];
            dac_track_enable_o <= lock_pin_control_word[TRACK_BIT];
            holdover_enable_o <= (holdover_mode == HMODE_ON);
        end
    end
endmodule : sync_status_pin_control

// >>> sim/sync_status_asserts.sv
`timescale 1ns/10ps
module sync_status_asserts
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic serial_latch_enable_pin_i,
    input wire logic sync_pin_oe_o,
    input wire logic sync_pin_pullup_o,
    input wire logic sync_pin_pulldown_o,
    input wire logic [sync_status_pkg::NUM_OUT-1:0] output_sync_hold_o,
    input wire logic [sync_status_pkg::NUM_OUT-1:0] delay_load_o,
    input wire logic crystal_amp_enable_o,
    input wire logic dac_track_enable_o,
    input wire logic holdover_enable_o
);
    import sync_status_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic hold_any = |output_sync_hold_o;
    load_cause_a: assert property ((delay_load_o & ~$past(output_sync_hold_o)) == '0)
        else $error("delay load without hold");
    load_pulse_a: assert property (|delay_load_o |=> delay_load_o == '0)
        else $error("delay load longer than one cycle");
    release_load_a: assert property ($fell(hold_any) |-> delay_load_o == $past(output_sync_hold_o))
        else $error("release load mask wrong");
    release_gap_a: assert property ($fell(hold_any) |=> !hold_any)
        else $error("sync restarted in release cycle");
    hold_load_a: assert property ((output_sync_hold_o & delay_load_o) == '0)
        else $error("load while held");
    pull_pair_a: assert property (!(sync_pin_pullup_o && sync_pin_pulldown_o))
        else $error("both pulls on");
    pull_input_a: assert property (sync_pin_pullup_o || sync_pin_pulldown_o |-> !sync_pin_oe_o)
        else $error("pull with driver on");
    cfg_latch_a: assert property ($changed({crystal_amp_enable_o, dac_track_enable_o,
        holdover_enable_o}) |-> $past(serial_latch_enable_pin_i) || $past(serial_latch_enable_pin_i, 2))
        else $error("config changed without latch");
    cover property (|delay_load_o);
    cover property ($rose(hold_any) ##[2:8] !hold_any);
    cover property (sync_pin_pullup_o);
endmodule : sync_status_asserts
bind sync_status_pin_control sync_status_asserts i_sync_status_asserts
(
    .clk_i(clk_i), .rst_i(rst_i), .serial_latch_enable_pin_i(serial_latch_enable_pin_i),
    .sync_pin_oe_o(sync_pin_oe_o), .sync_pin_pullup_o(sync_pin_pullup_o),
    .sync_pin_pulldown_o(sync_pin_pulldown_o), .output_sync_hold_o(output_sync_hold_o),
    .delay_load_o(delay_load_o), .crystal_amp_enable_o(crystal_amp_enable_o),
    .dac_track_enable_o(dac_track_enable_o), .holdover_enable_o(holdover_enable_o)
);

// >>> sim/serial_host.sv
`timescale 1ns/10ps
module serial_host
(
    // Clock
    input wire logic clk_i,
    // Serial port drive
    output logic sck_o = 1'b0,
    output logic sdo_o = 1'b0,
    output logic le_o = 1'b0
);
    task automatic step;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : step
    // Words keep output 2 powered, feedback mux on and holdover codes legal
    task automatic write_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            sdo_o = w[i];
            sck_o = 1'b0;
            step();
            sck_o = 1'b1;
            step();
        end
        // Clock parks low, data shows no stale bit
        sck_o = 1'b0;
        sdo_o = ~sdo_o;
        le_o = 1'b1;
        step();
        le_o = 1'b0;
        step();
    endtask : write_word
endmodule : serial_host

// >>> sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    import sync_status_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sck, sdo, le, sp_o, sp_oe, pu, pd, lk_o, lk_oe, ho_o, ho_oe, xt, trk, hen;
    logic rdbk = 1'b1, lvl = 1'b0;
    logic [1:0] lock = 2'h3;
    logic [18:0] src = '0;
    logic [6:0] fb = '0;
    logic [2:0] fsel = 3'h2;
    logic clr = 1'b0;
    logic [5:0] hold, load;
    logic [5:0] seen = '0;
    logic [3:0] ptab [7] = '{4'h0, 4'h8, 4'h4, 4'h3, 4'h1, 4'h3, 4'h0};
    pin_drive_type got;
    int errors = 0;
    int cmp_count = 0;
    wire logic pin = sp_oe ? sp_o : lvl;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) seen <= (clr ? 6'h0 : seen) | load;
    serial_host i_serial_host (.clk_i(clk_i), .sck_o(sck), .sdo_o(sdo), .le_o(le));
    sync_status_pin_control i_sync_status_pin_control
    (
        .clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sck), .serial_data_i(sdo),
        .serial_latch_enable_pin_i(le), .readback_data_i(rdbk), .status_src_i(src),
        .digital_lock_detect_loop1_i(lock[0]), .digital_lock_detect_loop2_i(lock[1]),
        .feedback_clk_i(fb), .feedback_select_i(fsel), .sync_pin_i(pin),
        .sync_pin_o(sp_o), .sync_pin_oe_o(sp_oe), .sync_pin_pullup_o(pu),
        .sync_pin_pulldown_o(pd), .lock_status_pin_o(lk_o), .lock_status_pin_oe_o(lk_oe),
        .holdover_pin_o(ho_o), .holdover_pin_oe_o(ho_oe), .output_sync_hold_o(hold),
        .delay_load_o(load), .crystal_amp_enable_o(xt), .dac_track_enable_o(trk),
        .holdover_enable_o(hen)
    );
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic clr_seen;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask : clr_seen
    task automatic wr(input logic [31:0] w);
        i_serial_host.write_word(w);
        cyc(3);
    endtask : wr
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [31:0] sw(input logic en, input logic [5:0] ex,
        input logic [2:0] qpa, input logic [2:0] ty, input logic x);
        sw = {5'h0, en, ex, SYNC_SRC_READBACK, qpa, ty, 6'h0, x, ADDR_SYNC_CTRL};
    endfunction : sw
    function automatic logic [1:0] pexp(input int t, input logic l);
        pexp = t == 3 ? {l, 1'b1} : t == 4 ? {~l, 1'b1} : t == 5 ? {1'b1, l} : {1'b0, ~l};
    endfunction : pexp
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    initial
    begin
        #4_000_000;
        errors++;
        complete_run();
    end
    initial
    begin
        cyc(8);
        rst_i = 1'b0;
        cyc(6);
        chk(32'({lk_o, lk_oe, ho_o, ho_oe, xt, trk, hen, sp_oe}), 32'h50);
        $display("test reset ended");
        wr(sw(1'b1, '0, '0, '0, 1'b1));
        wr(32'h0300018c);
        chk(32'({xt, trk, hen}), 32'h7);
        $display("test config ended");
        for (int t = 0; t < 7; t++)
        begin
            wr(sw(1'b1, '0, '0, 3'(t), 1'b0));
            chk(32'({pu, pd, sp_oe & sp_o, sp_oe}), 32'(ptab[t]));
            chk(32'(hold), 32'h0);
        end
        // Logic low source on an inverted output drives the pin high
        wr(sw(1'b1, '0, '0, 3'h4, 1'b0) & ~32'h000c_0000);
        chk(32'({sp_oe & sp_o, sp_oe}), 32'h3);
        $display("test sync pin ended");
        wr(sw(1'b1, 6'h03, 3'h2, 3'h4, 1'b0));
        chk(32'(hold), 32'h3c);
        clr_seen();
        wr(sw(1'b1, 6'h03, '0, 3'h4, 1'b0));
        chk(32'({hold, seen}), 32'h03c);
        $display("test polarity ended");
        wr(sw(1'b0, '0, '0, '0, 1'b0));
        lvl = 1'b1;
        cyc(4);
        chk(32'(hold), 32'h0);
        lvl = 1'b0;
        clr_seen();
        wr(sw(1'b1, '0, '0, '0, 1'b0));
        chk(32'(seen), 32'h3f);
        $display("test enable ended");
        wr(sw(1'b1, '0, 3'h1, '0, 1'b0));
        for (int a = 0; a < 5; a++)
        begin
            clr_seen();
            wr(a < 4 ? 32'(a * 5) : sw(1'b1, '0, '0, '0, 1'b0));
            chk(32'(seen), a < 2 ? 32'h3f : 32'h0);
        end
        clr_seen();
        wr(32'h2);
        chk(32'(seen), 32'h0);
        $display("test auto ended");
        for (int k = 0; k < 2; k++)
        begin
            lock[k] = 1'b0;
            wr(32'h0300004c | (32'h400000 << k));
            chk(32'(hold), 32'h3f);
            clr_seen();
            lock[k] = 1'b1;
            cyc(4);
            chk(32'({hold, seen}), 32'h03f);
            wr(32'h0300004c);
        end
        $display("test lock hold ended");
        wr(sw(1'b1, '0, 3'h4, '0, 1'b0));
        lvl = 1'b1;
        fb = 7'h08;
        cyc(4);
        chk(32'(hold), 32'h0);
        fb = 7'h04;
        cyc(3);
        chk(32'(hold), 32'h3f);
        lvl = 1'b0;
        fb = 7'h00;
        cyc(4);
        chk(32'(hold), 32'h3f);
        // Another selected clock: only its own rising edge releases
        fsel = 3'h3;
        fb = 7'h04;
        cyc(3);
        chk(32'(hold), 32'h3f);
        fb = 7'h0c;
        cyc(3);
        chk(32'(hold), 32'h0);
        wr(sw(1'b1, '0, '0, '0, 1'b0));
        $display("test qualify ended");
        for (int w = 0; w < 2; w++)
            for (int t = 3; t < 7; t++)
                for (int c = 0; c < NUM_SRC; c++)
                begin
                    src = (19'h1 << c) & ~19'h80;
                    rdbk = c == 7;
                    wr({5'(c), 3'(t), 24'h0} | (w == 1 ? 32'h4c : 32'h0d));
                    got = w == 1 ? {lk_o, lk_oe} : {ho_o, ho_oe};
                    chk(32'(got), 32'(pexp(t, c != 0 && c != 6)));
                end
        $display("test status pins ended");
        complete_run();
    end
endmodule : testbench
